// file: spcr_pkg.sv
package spcr_pkg;
    // Register byte addresses
    localparam logic [4:0] ADDR_RCS   = 5'h00;
    localparam logic [4:0] ADDR_RATE  = 5'h04;
    localparam logic [4:0] ADDR_RXH   = 5'h08;
    localparam logic [4:0] ADDR_TXH   = 5'h0c;
    localparam logic [4:0] ADDR_DIVL  = 5'h10;
    localparam logic [4:0] ADDR_DIVH  = 5'h14;
    localparam logic [4:0] ADDR_MODE  = 5'h18;

    // Receive control/status field positions
    localparam int RCS_EN    = 7;
    localparam int RCS_RX9   = 6;
    localparam int RCS_SINGLE_RECEIVE_ENABLE  = 5;
    localparam int RCS_CONTINUOUS_RECEIVE_ENABLE  = 4;
    localparam int RCS_ADDRESS_DETECT_ENABLE = 3;
    localparam int RCS_FRAMING_FLAG  = 2;
    localparam int RCS_OVERRUN_FLAG  = 1;
    localparam int RCS_RECEIVED_NINTH_BIT  = 0;

    // Rate control field positions
    localparam int RT_OVF  = 7;
    localparam int RT_IDLE = 6;
    localparam int RT_POL  = 4;
    localparam int RT_WIDE = 3;
    localparam int RT_WUE  = 1;
    localparam int RT_ABD  = 0;

    // Mode register: bit0 sync, bit1 host, bit2 high speed, bit3 tx9, bit4 tx ninth bit
    localparam int MD_SYNC = 0;
    localparam int MD_HOST = 1;
    localparam int MD_HS   = 2;
    localparam int MD_TX9  = 3;
    localparam int MD_TRANSMIT_NINTH_BIT = 4;
    localparam int MD_SHIFT_REGISTER_EMPTY = 5;

    // Writable masks (unimplemented bits read zero)
    localparam logic [7:0] RCS_WMASK  = 8'hf8;
    localparam logic [7:0] RATE_WMASK = 8'h1b;
    localparam logic [7:0] MODE_WMASK = 8'h1f;

    // Rate generator prescales
    localparam logic [5:0] PRE_SLOW = 6'h3f;
    localparam logic [5:0] PRE_MID  = 6'h0f;
    localparam logic [5:0] PRE_FAST = 6'h03;

    localparam logic [7:0] SYNC_CHAR = 8'h55;
    localparam logic [1:0] RESP_OK     = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Received character with ninth and stop bits
    typedef struct packed {
        logic       stop_bad;
        logic       ninth;
        logic [7:0] data;
    } spcr_char_t;

    typedef enum logic [1:0] {
        SPCR_IDLE  = 2'b00,
        SPCR_START = 2'b01,
        SPCR_DATA  = 2'b10,
        SPCR_STOP  = 2'b11
    } spcr_state_t;
endpackage : spcr_pkg

// file: spcr_remote.sv
`timescale 1ns/100ps
// Far-side asynchronous transceiver: drives the receive line, decodes transmit line
module spcr_remote #(
    parameter int BIT = 16
) (
    // Clock
    input  wire logic clk,
    // Line into the device receiver
    output logic      line_out,
    // Line from the device transmitter
    input  wire logic line_in
);
    // Idle high between frames
    initial line_out = 1'b1;

    // One frame: start, nine data bits LSB first, stop level, idle gap
    task automatic send(input logic [8:0] d, input logic stop);
        int i;
        @(posedge clk) line_out <= 1'b0;
        repeat (BIT) @(posedge clk);
        for (i = 0; i < 9; i++) begin
            line_out <= d[i];
            repeat (BIT) @(posedge clk);
        end
        line_out <= stop;
        repeat (BIT) @(posedge clk);
        line_out <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask : send

    // Sample eight bits at mid-bit, then the stop bit
    task automatic catch_char(output logic [7:0] d, output logic stp);
        int i;
        while (line_in !== 1'b0) @(posedge clk);
        repeat (BIT / 2) @(posedge clk);
        for (i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            d[i] = line_in;
        end
        repeat (BIT) @(posedge clk);
        stp = line_in;
    endtask : catch_char
endmodule : spcr_remote

// file: spcr_rxbuf.sv
`timescale 1ns/100ps
// Two-entry receive holding buffer, registered head output
module spcr_rxbuf #(
    parameter int W = 10
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         clr,
    // Fill side
    input  wire logic         push,
    input  wire logic [W-1:0] wdata,
    // Drain side
    input  wire logic         pop,
    output logic      [W-1:0] head,
    output logic      [1:0]   count
);
    logic [W-1:0] mem [2];
    logic         wp;
    logic         rp;

    // Storage and pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem[0] <= '0;
            mem[1] <= '0;
            wp     <= 1'b0;
            rp     <= 1'b0;
            count  <= 2'h0;
        end else if (clr) begin
            wp    <= 1'b0;
            rp    <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push && count != 2'h2) begin
                mem[wp] <= wdata;
                wp      <= ~wp;
            end
            if (pop && count != 2'h0)
                rp <= ~rp;
            count <= count + 2'((push && count != 2'h2) ? 1 : 0)
                           - 2'((pop && count != 2'h0) ? 1 : 0);
        end
    end

    // Registered head word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            head <= '0;
        else if (count == 2'h0 || (pop && count == 2'h1))
            head <= wdata;
        else if (pop)
            head <= mem[~rp];
        else
            head <= mem[rp];
    end
endmodule : spcr_rxbuf

// file: spcr_top.sv
`timescale 1ns/100ps
module spcr_top (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // AXI4-Lite write
    input  wire logic [4:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read
    input  wire logic [4:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // Serial pins; enables low while driving
    input  wire logic        RX_DT_IN,
    output logic             DT_OUT,
    output logic             DT_OE_N,
    input  wire logic        TX_CK_IN,
    output logic             TX_CK_OUT,
    output logic             TX_CK_OE_N
);
    logic [7:0]  rcs;
    logic [7:0]  rate;
    logic [7:0]  mode;
    logic [7:0]  divl;
    logic [7:0]  divh;
    logic [7:0]  txh;
    logic        txh_full;
    logic        wr_go;
    logic        rd_go;
    logic [4:0]  aw_q;
    logic [31:0] w_q;
    logic        aw_have;
    logic        w_have;
    logic        brg_clr;
    logic        port_on;
    logic        sync_m;
    logic        host_m;
    logic        rx_pop;
    logic        rx_push;
    logic        buf_clr;
    logic [1:0]  rx_cnt;
    spcr_pkg::spcr_char_t rx_head;
    spcr_pkg::spcr_char_t next_char;

    assign port_on = rcs[spcr_pkg::RCS_EN];
    assign sync_m  = mode[spcr_pkg::MD_SYNC];
    assign host_m  = mode[spcr_pkg::MD_HOST];

    // Write address/data capture in either order
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            aw_q    <= 5'h00;
            w_q     <= 32'h0000_0000;
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_have <= 1'b1;
                aw_q    <= AWADDR;
                AWREADY <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_have <= 1'b1;
                w_q    <= WDATA & {{8{WSTRB[3]}}, {8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};
                WREADY <= 1'b0;
            end
            if (wr_go) begin
                aw_have <= 1'b0;
                w_have  <= 1'b0;
            end
            if (BVALID && BREADY) begin
                AWREADY <= 1'b1;
                WREADY  <= 1'b1;
            end
        end
    end
    assign wr_go = aw_have && w_have && !BVALID;

    // Write response
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            BVALID <= 1'b0;
            BRESP  <= spcr_pkg::RESP_OK;
        end else if (wr_go) begin
            BVALID <= 1'b1;
            BRESP  <= (aw_q > spcr_pkg::ADDR_MODE || aw_q[1:0] != 2'b00 || aw_q == spcr_pkg::ADDR_RXH)
                      ? spcr_pkg::RESP_SLVERR : spcr_pkg::RESP_OK;
        end else if (BREADY)
            BVALID <= 1'b0;
    end

    // Rate generator: prescale times divider plus one
    logic [5:0]  pre_max;
    logic [15:0] div_val;
    logic [5:0]  pre_cnt;
    logic [15:0] div_cnt;
    logic        tick;
    always_comb begin
        div_val = rate[spcr_pkg::RT_WIDE] ? {divh, divl} : {8'h00, divl};
        if (sync_m || (rate[spcr_pkg::RT_WIDE] && mode[spcr_pkg::MD_HS]))
            pre_max = spcr_pkg::PRE_FAST;
        else if (rate[spcr_pkg::RT_WIDE] || mode[spcr_pkg::MD_HS])
            pre_max = spcr_pkg::PRE_MID;
        else
            pre_max = spcr_pkg::PRE_SLOW;
    end
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_cnt <= 6'h00;
            div_cnt <= 16'h0000;
            tick    <= 1'b0;
        end else if (brg_clr || !port_on) begin
            pre_cnt <= 6'h00;
            div_cnt <= 16'h0000;
            tick    <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (pre_cnt >= pre_max) begin
                pre_cnt <= 6'h00;
                if (div_cnt >= div_val) begin
                    div_cnt <= 16'h0000;
                    tick    <= 1'b1;
                end else
                    div_cnt <= div_cnt + 16'h0001;
            end else
                pre_cnt <= pre_cnt + 6'h01;
        end
    end

    // Transmitter: holding register feeds shift register
    logic [10:0] transmit_shift_register;
    logic [3:0]  tx_left;
    logic        tx_busy;
    logic        ck_phase;
    logic        tx_line;
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            transmit_shift_register      <= 11'h7ff;
            tx_left  <= 4'h0;
            tx_busy  <= 1'b0;
            txh_full <= 1'b0;
            ck_phase <= 1'b0;
        end else if (!port_on) begin
            transmit_shift_register      <= 11'h7ff;
            tx_left  <= 4'h0;
            tx_busy  <= 1'b0;
            txh_full <= 1'b0;
            ck_phase <= 1'b0;
        end else begin
            // Load only on a bit tick so the start bit lasts a full bit time
            if (!tx_busy && txh_full && tick) begin
                // Frame: start, data, optional ninth, stop
                transmit_shift_register      <= {1'b1, mode[spcr_pkg::MD_TRANSMIT_NINTH_BIT], txh, 1'b0};
                tx_left  <= mode[spcr_pkg::MD_TX9] ? 4'ha : 4'h9;
                tx_busy  <= 1'b1;
                txh_full <= 1'b0;
            end else if (tx_busy && tick) begin
                ck_phase <= ~ck_phase;
                if (!sync_m || ck_phase) begin
                    transmit_shift_register     <= {1'b1, transmit_shift_register[10:1]};
                    tx_left <= tx_left - 4'h1;
                    if (tx_left == 4'h1)
                        tx_busy <= 1'b0;
                end
            end
            // New write wins over the load clear in the same cycle
            if (wr_go && aw_q == spcr_pkg::ADDR_TXH)
                txh_full <= 1'b1;
        end
    end
    assign tx_line = tx_busy ? transmit_shift_register[0] : 1'b1;

    // Pin drivers
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            TX_CK_OUT  <= 1'b1;
            TX_CK_OE_N <= 1'b1;
            DT_OUT     <= 1'b1;
            DT_OE_N    <= 1'b1;
        end else begin
            TX_CK_OE_N <= !(port_on && (!sync_m || host_m));
            DT_OE_N    <= !(port_on && sync_m && tx_busy);
            DT_OUT     <= tx_line;
            if (!sync_m)
                TX_CK_OUT <= rate[spcr_pkg::RT_POL] ? ~tx_line : tx_line;
            else
                TX_CK_OUT <= rate[spcr_pkg::RT_POL] ^ (tx_busy & ck_phase);
        end
    end

    // Receiver: bit-rate sampling of the data line
    spcr_pkg::spcr_state_t st;
    logic [3:0]  rx_bits;
    logic [8:0]  rsr;
    logic [15:0] abd_cnt;
    logic        abd_run;
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st      <= spcr_pkg::SPCR_IDLE;
            rx_bits <= 4'h0;
            rsr     <= 9'h000;
            rx_push <= 1'b0;
            next_char <= '0;
        end else if (!port_on) begin
            st      <= spcr_pkg::SPCR_IDLE;
            rx_push <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            case (st)
                spcr_pkg::SPCR_IDLE: begin
                    // Async waits for a start bit; next tick already holds bit 0
                    if (tick && (sync_m || !RX_DT_IN) && (rcs[spcr_pkg::RCS_CONTINUOUS_RECEIVE_ENABLE] ||
                        (sync_m && host_m && rcs[spcr_pkg::RCS_SINGLE_RECEIVE_ENABLE]))) begin
                        st <= spcr_pkg::SPCR_DATA;
                        rx_bits <= rcs[spcr_pkg::RCS_RX9] ? 4'h9 : 4'h8;
                    end
                end
                spcr_pkg::SPCR_START: begin
                    if (tick)
                        st <= spcr_pkg::SPCR_DATA;
                end
                spcr_pkg::SPCR_DATA: begin
                    if (tick) begin
                        rsr     <= {RX_DT_IN, rsr[8:1]};
                        rx_bits <= rx_bits - 4'h1;
                        if (rx_bits == 4'h1)
                            st <= spcr_pkg::SPCR_STOP;
                    end
                end
                spcr_pkg::SPCR_STOP: begin
                    if (tick) begin
                        next_char.stop_bad <= !sync_m && !RX_DT_IN;
                        next_char.ninth    <= rcs[spcr_pkg::RCS_RX9] ? rsr[8] : 1'b0;
                        next_char.data     <= rcs[spcr_pkg::RCS_RX9] ? rsr[7:0] : rsr[8:1];
                        rx_push <= 1'b1;
                        st      <= spcr_pkg::SPCR_IDLE;
                    end
                end
                default: st <= spcr_pkg::SPCR_IDLE;
            endcase
        end
    end

    // Double-buffered receive holding
    assign rx_pop  = rd_go && ARADDR == spcr_pkg::ADDR_RXH;
    assign buf_clr = !port_on;
    spcr_rxbuf #(.W(10)) u_rxbuf (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .clr   (buf_clr),
        .push  (rx_push),
        .wdata (next_char),
        .pop   (rx_pop),
        .head  (rx_head),
        .count (rx_cnt)
    );

    // Auto rate measurement over the sync character
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            abd_cnt <= 16'h0000;
            abd_run <= 1'b0;
        end else if (!port_on || !rate[spcr_pkg::RT_ABD]) begin
            abd_cnt <= 16'h0000;
            abd_run <= 1'b0;
        end else if (!abd_run && !RX_DT_IN) begin
            abd_run <= 1'b1;
            abd_cnt <= 16'h0000;
        end else if (abd_run)
            abd_cnt <= abd_cnt + 16'h0001;
    end

    // Software-visible registers
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rcs     <= 8'h00;
            rate    <= 8'h40;
            mode    <= 8'h20;
            divl    <= 8'h00;
            divh    <= 8'h00;
            txh     <= 8'h00;
            brg_clr <= 1'b0;
        end else begin
            brg_clr <= 1'b0;
            if (wr_go) begin
                case (aw_q)
                    spcr_pkg::ADDR_RCS:  rcs  <= (w_q[7:0] & spcr_pkg::RCS_WMASK) | (rcs & ~spcr_pkg::RCS_WMASK);
                    spcr_pkg::ADDR_RATE: rate <= (w_q[7:0] & spcr_pkg::RATE_WMASK) | (rate & ~spcr_pkg::RATE_WMASK);
                    spcr_pkg::ADDR_MODE: mode[4:0] <= w_q[4:0] & spcr_pkg::MODE_WMASK[4:0];
                    spcr_pkg::ADDR_TXH:  txh  <= w_q[7:0];
                    spcr_pkg::ADDR_DIVL: begin
                        divl    <= w_q[7:0];
                        brg_clr <= 1'b1;
                    end
                    spcr_pkg::ADDR_DIVH: begin
                        divh    <= w_q[7:0];
                        brg_clr <= 1'b1;
                    end
                    default: ;
                endcase
            end
            // Hardware status updates, set over software writes
            if (!port_on) begin
                rcs[spcr_pkg::RCS_OVERRUN_FLAG] <= 1'b0;
            end else if (rx_push && rx_cnt == 2'h2)
                rcs[spcr_pkg::RCS_OVERRUN_FLAG] <= 1'b1;
            else if (!rcs[spcr_pkg::RCS_CONTINUOUS_RECEIVE_ENABLE])
                rcs[spcr_pkg::RCS_OVERRUN_FLAG] <= 1'b0;
            rcs[spcr_pkg::RCS_FRAMING_FLAG] <= rx_cnt != 2'h0 && rx_head.stop_bad;
            rcs[spcr_pkg::RCS_RECEIVED_NINTH_BIT] <= rx_head.ninth;
            if (rx_push && sync_m && host_m && !rcs[spcr_pkg::RCS_CONTINUOUS_RECEIVE_ENABLE])
                rcs[spcr_pkg::RCS_SINGLE_RECEIVE_ENABLE] <= 1'b0;
            rate[spcr_pkg::RT_IDLE] <= st == spcr_pkg::SPCR_IDLE;
            mode[spcr_pkg::MD_SHIFT_REGISTER_EMPTY] <= !tx_busy;
            if (abd_run && abd_cnt == 16'hffff)
                rate[spcr_pkg::RT_OVF] <= 1'b1;
            else if (wr_go && aw_q == spcr_pkg::ADDR_RATE && !w_q[spcr_pkg::RT_OVF])
                rate[spcr_pkg::RT_OVF] <= 1'b0;
            if (abd_run && rx_push) begin
                rate[spcr_pkg::RT_ABD] <= 1'b0;
                divl <= abd_cnt[11:4];
                divh <= {4'h0, abd_cnt[15:12]};
            end
        end
    end

    // Read channel
    assign rd_go = ARVALID && ARREADY;
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= spcr_pkg::RESP_OK;
        end else if (rd_go) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RRESP   <= spcr_pkg::RESP_OK;
            case (ARADDR)
                spcr_pkg::ADDR_RCS:  RDATA <= {24'h0, rcs};
                spcr_pkg::ADDR_RATE: RDATA <= {24'h0, rate};
                spcr_pkg::ADDR_RXH:  RDATA <= {24'h0, rx_head.data};
                spcr_pkg::ADDR_TXH:  RDATA <= {24'h0, txh};
                spcr_pkg::ADDR_DIVL: RDATA <= {24'h0, divl};
                spcr_pkg::ADDR_DIVH: RDATA <= {24'h0, divh};
                spcr_pkg::ADDR_MODE: RDATA <= {24'h0, mode};
                default: begin
                    RDATA <= 32'h0000_0000;
                    RRESP <= spcr_pkg::RESP_SLVERR;
                end
            endcase
        end else if (RVALID && RREADY) begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

    // Checks
    a_div_restart: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        brg_clr |=> pre_cnt == 6'h00 && div_cnt == 16'h0000) else $error("divider not restarted");
    a_narrow_div: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !rate[spcr_pkg::RT_WIDE] |-> div_val[15:8] == 8'h00) else $error("high byte used");
    a_rate_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        rate[5] == 1'b0 && rate[2] == 1'b0) else $error("reserved bit set");
    a_off_quiet: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !port_on |=> TX_CK_OE_N && !tx_busy) else $error("pins driven while off");
    a_async_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        port_on && !sync_m && !tx_busy && $stable(rate[spcr_pkg::RT_POL]) |=>
        TX_CK_OUT == !$past(rate[spcr_pkg::RT_POL])) else $error("idle level wrong");
    a_sync_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        port_on && sync_m && !tx_busy |=> TX_CK_OUT == $past(rate[spcr_pkg::RT_POL]))
        else $error("clock idle wrong");
    a_ovr_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        port_on && rx_push && rx_cnt == 2'h2 |=> rcs[spcr_pkg::RCS_OVERRUN_FLAG]) else $error("overrun lost");
    a_slow_pre: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !sync_m && !rate[spcr_pkg::RT_WIDE] && !mode[spcr_pkg::MD_HS] |-> pre_max == 6'h3f)
        else $error("prescale wrong");
endmodule : spcr_top

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
    // Design-facing signals
    logic        CORE_CLK, RST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic        ARVALID, ARREADY, RVALID, RREADY, RX_DT_IN, DT_OUT, DT_OE_N;
    logic        TX_CK_IN, TX_CK_OUT, TX_CK_OE_N, s, ovr;
    logic [4:0]  AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, v;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP, r;
    logic [7:0]  c1, c2, g, dh;
    int          fails = 0, n_tests = 0, e;
    int          rxq[$];

    spcr_top DUT (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .RX_DT_IN(RX_DT_IN), .DT_OUT(DT_OUT), .DT_OE_N(DT_OE_N), .TX_CK_IN(TX_CK_IN),
        .TX_CK_OUT(TX_CK_OUT), .TX_CK_OE_N(TX_CK_OE_N)
    );
    spcr_remote #(.BIT(16)) remote (.clk(CORE_CLK), .line_out(RX_DT_IN), .line_in(TX_CK_OUT));

    // 25 MHz clock
    initial begin
        CORE_CLK = 1'b0;
        forever #20 CORE_CLK = ~CORE_CLK;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bus write, address and data offered together
    task automatic wr(input logic [4:0] a, input logic [7:0] d, output logic [1:0] rs);
        @(posedge CORE_CLK);
        AWADDR <= a;
        WDATA <= {24'h0, d};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1);
        rs = BRESP;
        BREADY <= 1'b0;
    endtask : wr

    // Bus read
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge CORE_CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1);
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
    endtask : rd

    // Send a character; model keeps two, a third sets overrun
    task automatic snd(input logic [8:0] d, input logic stop);
        remote.send(d, stop);
        if (rxq.size() < 2) rxq.push_back({!stop, d});
        else ovr = 1'b1;
    endtask : snd

    // Read head flags and data against the model
    task automatic pop_chk;
        e = rxq.pop_front();
        rd(spcr_pkg::ADDR_RCS, v);
        chk(v[0], e[8]);
        chk(v[2], e[9]);
        rd(spcr_pkg::ADDR_RXH, v);
        chk(v, e & 255);
    endtask : pop_chk

    // Transmit two characters back to back and decode both
    task automatic tx2;
        c1 = 8'($urandom);
        c2 = 8'($urandom);
        fork
            begin
                wr(spcr_pkg::ADDR_TXH, c1, r);
                // Holding register is free once the shift register is busy
                do rd(spcr_pkg::ADDR_MODE, v); while (v[spcr_pkg::MD_SHIFT_REGISTER_EMPTY] === 1'b1);
                wr(spcr_pkg::ADDR_TXH, c2, r);
            end
            begin
                remote.catch_char(g, s);
                chk(g, c1);
                chk(s, 1'b1);
                remote.catch_char(g, s);
                chk(g, c2);
            end
        join
    endtask : tx2

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    // Watchdog
    initial begin
        #600000;
        fails++;
        wrap_up();
    end

    // Main sequence
    initial begin
        {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, ovr} = '0;
        {AWADDR, ARADDR, WDATA} = '0;
        WSTRB = 4'hf;
        TX_CK_IN = 1'b1;
        void'($urandom(43));
        repeat (5) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        rd(spcr_pkg::ADDR_RATE, v);
        chk(v, 32'h40);
        chk(r, spcr_pkg::RESP_OK);
        chk(TX_CK_OE_N, 1'b1);
        wr(spcr_pkg::ADDR_RATE, 8'hfc, r);
        rd(spcr_pkg::ADDR_RATE, v);
        chk(v, 32'h58);
        wr(spcr_pkg::ADDR_RCS, 8'hd0, r);
        repeat (2) @(posedge CORE_CLK);
        chk(TX_CK_OE_N, 1'b0);
        chk(TX_CK_OUT, 1'b0);
        wr(spcr_pkg::ADDR_RATE, 8'h08, r);
        repeat (2) @(posedge CORE_CLK);
        chk(TX_CK_OUT, 1'b1);
        chk(DT_OE_N, 1'b1);
        chk(DT_OUT, 1'b1);
        tx2();
        snd({1'b1, 8'($urandom)}, 1'b1);
        snd({1'b0, 8'($urandom)}, 1'b0);
        pop_chk();
        pop_chk();
        repeat (3) snd(9'($urandom), 1'b1);
        rd(spcr_pkg::ADDR_RCS, v);
        chk(v[1], ovr);
        pop_chk();
        pop_chk();
        wr(spcr_pkg::ADDR_RCS, 8'hc0, r);
        rd(spcr_pkg::ADDR_RCS, v);
        chk(v[1], 1'b0);
        dh = 8'($urandom_range(255, 1));
        wr(spcr_pkg::ADDR_DIVH, dh, r);
        rd(spcr_pkg::ADDR_DIVH, v);
        chk(v, {24'h0, dh});
        wr(spcr_pkg::ADDR_RATE, 8'h00, r);
        wr(spcr_pkg::ADDR_MODE, 8'h04, r);
        tx2();
        wr(spcr_pkg::ADDR_DIVL, dh ^ 8'h5a, r);
        rd(spcr_pkg::ADDR_DIVL, v);
        chk(v, {24'h0, dh ^ 8'h5a});
        wr(spcr_pkg::ADDR_RXH, 8'h11, r);
        chk(r, spcr_pkg::RESP_SLVERR);
        wr(5'h1c, 8'h11, r);
        chk(r, spcr_pkg::RESP_SLVERR);
        rd(5'h1c, v);
        chk(r, spcr_pkg::RESP_SLVERR);
        chk(v, 32'h0);
        wr(spcr_pkg::ADDR_MODE, 8'h03, r);
        wr(spcr_pkg::ADDR_RATE, 8'h10, r);
        repeat (2) @(posedge CORE_CLK);
        chk(TX_CK_OUT, 1'b1);
        wr(spcr_pkg::ADDR_RATE, 8'h00, r);
        repeat (2) @(posedge CORE_CLK);
        chk(TX_CK_OUT, 1'b0);
        // Sync host single receive of an idle-high line, four cycles a bit
        wr(spcr_pkg::ADDR_DIVL, 8'h00, r);
        wr(spcr_pkg::ADDR_RCS, 8'ha0, r);
        rd(spcr_pkg::ADDR_RCS, v);
        chk(v[5], 1'b1);
        repeat (60) @(posedge CORE_CLK);
        rd(spcr_pkg::ADDR_RCS, v);
        chk(v[5], 1'b0);
        rd(spcr_pkg::ADDR_RXH, v);
        chk(v, 32'hff);
        wrap_up();
    end
endmodule : testbench
